//--- aptc_asserts.sv
`timescale 1ns/100ps
module aptc_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] trig_in,
  input wire logic conv_done,
  input wire logic conv_clk,
  input wire logic [1:0] sample_en,
  input wire logic [1:0] conv_start,
  input wire logic [1:0] irq_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  bus_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  bit3_zero_a: assert property (
    pready && !pwrite && paddr == 12'h000 |->
    prdata[3] == 1'b0 && prdata[31:16] == 16'h0)
    else $error("main control reserved bits set");
  irq3_done_a: assert property (irq_req[1] |-> $past(conv_done,2))
    else $error("pair3 irq without done");
  irq2_done_a: assert property (irq_req[0] |-> $past(conv_done,2))
    else $error("pair2 irq without done");
  one_grant_a: assert property (conv_start != 2'b11)
    else $error("both pairs granted");
  grant_pulse_a: assert property (|conv_start |=> !conv_start)
    else $error("grant longer than one cycle");
  hold_first_a: assert property (conv_start[1] |-> !sample_en[1])
    else $error("pair3 still sampling at grant");
endmodule : aptc_asserts

//--- aptc_core_model.sv
`timescale 1ns/100ps
module aptc_core_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] conv_start,
  input wire logic [1:0] sample_en,
  input wire logic [7:0] latency,
  output logic conv_done
);
  logic [7:0] cnt;
  logic busy;
  logic hold;
  logic [1:0] who;
  // In sync mode a granted pair samples first; conversion runs only once its S&H has
  // let go, else a done pulse would reach a pair still sampling
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      hold <= 1'b0;
      who <= 2'h0;
      cnt <= 8'h0;
    end else if (|conv_start) begin
      hold <= 1'b1;
      who <= conv_start;
    end else if (hold) begin
      if (!(|(sample_en & who))) begin
        hold <= 1'b0;
        busy <= 1'b1;
        cnt <= latency;
      end
    end else if (busy && cnt != 8'h0) begin
      cnt <= cnt - 8'h1;
    end else begin
      busy <= 1'b0;
    end
  end
  assign conv_done = busy && cnt == 8'h0;
endmodule : aptc_core_model

//--- aptc_defs.svh
`ifndef APTC_DEFS_SVH
`define APTC_DEFS_SVH
`define APTC_OFF_MAIN_CTRL 12'h000
`define APTC_OFF_PAIR_CTRL 12'h004
`define APTC_OFF_STATUS 12'h008
`define APTC_MAIN_ON_BIT 15
`define APTC_MAIN_ASYNC_BIT 4
`define APTC_MAIN_DIV_LSB 0
`define APTC_MAIN_DIV_W 3
`define APTC_MAIN_DIV_RESET 3'h3
`define APTC_MAIN_WMASK 16'h8017
`define APTC_P3_IRQ_BIT 15
`define APTC_P3_PEND_BIT 14
`define APTC_P3_SWT_BIT 13
`define APTC_P3_SEL_LSB 8
`define APTC_P2_IRQ_BIT 7
`define APTC_P2_PEND_BIT 6
`define APTC_P2_SWT_BIT 5
`define APTC_P2_SEL_LSB 0
`define APTC_SEL_W 5
`define APTC_SEL_SOFT 5'h01
`define APTC_SAMPLE_ADC_CYCLES 2
`endif

//--- aptc_pair_if.sv
`timescale 1ns/100ps
interface aptc_pair_if;
  logic start;
  logic async_mode;
  logic adc_tick;
  logic grant;
  logic conv_done;
  logic pending;
  logic want;
  logic sampling;
  logic irq_event;
  modport ctrl (
    output start, async_mode, adc_tick, grant, conv_done,
    input pending, want, sampling, irq_event
  );
  modport pair (
    input start, async_mode, adc_tick, grant, conv_done,
    output pending, want, sampling, irq_event
  );
endinterface : aptc_pair_if

//--- aptc_pair_seq.sv
`timescale 1ns/100ps
`include "aptc_defs.svh"
module aptc_pair_seq (
  input wire logic sys_clk,
  input wire logic rstn,
  aptc_pair_if.pair pif
);
  import aptc_pkg::*;
  aptc_pair_state_t state;
  aptc_pair_state_t next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic pend;
  logic next_pend;
  logic irq;
  logic next_irq;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pend = pend;
    next_irq = 1'b0;
    if (pif.start) begin
      next_pend = 1'b1; // see [R8]
    end
    case (state)
      APTC_IDLE: begin
        if (pend && pif.grant) begin
          next_state = APTC_CONVERT;
        end
      end
      APTC_SAMPLE: begin
        if (pif.adc_tick) begin
          next_cnt = cnt + 2'h1;
          if (cnt == 2'(`APTC_SAMPLE_ADC_CYCLES - 1)) begin
            next_state = APTC_CONVERT; // see [R3]
          end
        end
      end
      APTC_CONVERT: begin
        if (pif.conv_done) begin
          next_state = APTC_IDLE;
          next_pend = pif.start; // see [R8]
          next_irq = 1'b1;
        end
      end
      default: next_state = APTC_IDLE;
    endcase
    // Queued request waits for the shared converter, then samples, or converts at once in async mode
    if (state == APTC_IDLE && pend && pif.grant) begin
      // see [R12]
      if (pif.async_mode) begin
        next_state = APTC_CONVERT; // see [R2]
      end else begin
        next_state = APTC_SAMPLE; // see [R3]
        next_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= APTC_IDLE;
      cnt <= 2'h0;
      pend <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pend <= next_pend;
      irq <= next_irq;
    end
  end

  assign pif.pending = pend;
  assign pif.want = pend && (state == APTC_IDLE);
  // Async mode tracks continuously until the trigger is seen
  assign pif.sampling = (state == APTC_SAMPLE) ||
    (pif.async_mode && !pend && state == APTC_IDLE); // see [R2]
  assign pif.irq_event = irq;
endmodule : aptc_pair_seq

//--- aptc_pkg.sv
package aptc_pkg;
  typedef enum logic [1:0] {
    APTC_IDLE,
    APTC_SAMPLE,
    APTC_CONVERT
  } aptc_pair_state_t;
  typedef logic [4:0] aptc_sel_t;
endpackage : aptc_pkg

//--- aptc_tb.sv
`timescale 1ns/100ps
module tb;
  logic sys_clk, rstn, psel, penable, pwrite, conv_done, pready, pslverr;
  logic conv_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trig_in;
  logic [1:0] sample_en, conv_start, irq_req;
  logic [7:0] latency;
  logic [32:0] exp_q[$];
  int n_errors, n_checks, n_clk, n_irq3, n_irq2, n_start, cyc, r, k;
  aptc_top dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .conv_done(conv_done), .conv_clk(conv_clk),
    .sample_en(sample_en), .conv_start(conv_start), .irq_req(irq_req));
  aptc_core_model core (.sys_clk(sys_clk), .rstn(rstn),
    .conv_start(conv_start), .sample_en(sample_en), .latency(latency),
    .conv_done(conv_done));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(string name, logic [32:0] e, logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  // Idle edge at the end keeps back-to-back calls from double driving
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
      logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  // Monitor on the falling edge, where outputs have settled
  always @(negedge sys_clk) begin
    cyc++;
    n_clk += (conv_clk === 1'b1);
    n_irq3 += (irq_req[1] === 1'b1);
    n_irq2 += (irq_req[0] === 1'b1);
    n_start += (conv_start[1] === 1'b1) + (conv_start[0] === 1'b1);
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", exp_q.pop_front(), {pslverr, prdata});
    if (cyc > 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {rstn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    trig_in = 32'h0;
    latency = 8'd20;
    void'($urandom(87387));
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    apb(0, 12'h000, 0, 33'h3);
    apb(0, 12'h004, 0, 33'h0);
    apb(0, 12'h00c, 0, 33'h1_0000_0000);
    apb(1, 12'h000, 32'h1f, 0);
    apb(0, 12'h000, 0, 33'h17);
    apb(1, 12'h000, 32'h8012, 0);
    apb(1, 12'h000, 32'h8005, 0);
    apb(0, 12'h000, 0, 33'h8012);
    $display("register test done");
    for (int d = 0; d < 8; d++) begin
      apb(1, 12'h000, 32'h0, 0);
      apb(1, 12'h000, 32'h8010 | d, 0);
      repeat (10) @(posedge sys_clk);
      k = n_clk;
      repeat (8 * (d + 1)) @(posedge sys_clk);
      chk("conv_clk", 8, n_clk - k);
      chk("async sample", 2'b11, sample_en);
    end
    $display("divider test done");
    apb(1, 12'h000, 32'h0, 0);
    apb(1, 12'h000, 32'h8003, 0);
    // Registered output still shows the async level for one more edge
    repeat (2) @(posedge sys_clk);
    chk("idle sample", 0, sample_en);
    apb(1, 12'h004, 32'h8181, 0);
    apb(1, 12'h004, 32'ha1a1, 0);
    repeat (6) @(posedge sys_clk);
    apb(0, 12'h004, 0, 33'hc1c1);
    repeat (150) @(posedge sys_clk);
    apb(0, 12'h004, 0, 33'h8181);
    chk("irq3", 1, n_irq3);
    chk("irq2", 1, n_irq2);
    chk("grants", 2, n_start);
    $display("soft trigger test done");
    r = 2 + $urandom % 30;
    latency <= 8'd3;
    apb(1, 12'h004, 32'h0080 | r, 0);
    trig_in[r] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    trig_in <= 32'h0;
    repeat (60) @(posedge sys_clk);
    chk("irq2 hw", 2, n_irq2);
    apb(1, 12'h004, 32'h0020 | r, 0);
    repeat (60) @(posedge sys_clk);
    chk("grants", 3, n_start);
    apb(0, 12'h008, 0, 33'h0);
    $display("hardware trigger test done");
    stop_test();
  end
endmodule : tb
bind aptc_top aptc_asserts chk_i (.sys_clk(sys_clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trig_in(trig_in), .conv_done(conv_done), .conv_clk(conv_clk),
  .sample_en(sample_en), .conv_start(conv_start), .irq_req(irq_req));

//--- aptc_top.sv
`timescale 1ns/100ps
`include "aptc_defs.svh"
// Notes on behaviour
// [R1] Each pair's sample-and-hold starts on its own trigger, independently. Sync-mode sampling here waits for the shared converter grant.
// [R2] Async mode: sample continuously, stop at once when trigger seen.
// [R3] Sync mode: sampling starts on trigger, lasts two ADC clock cycles.
// [R4] Divider field bits 2:0 divides input clock by value plus one.
// [R5] Async bit and divider change only while converter is off.
// [R6] Main control bit 3 reads as zero.
// [R7] Pair-3 interrupt enable raises request when pair-3 conversion ends.
// [R8] Pending sets on selected trigger, clears when conversion completes.
// [R9] Soft trigger bit starts pair-3 conversion when source selects software.
// [R10] Soft trigger bit clears when the pending bit becomes set.
// [R11] Software selects software source before setting soft trigger.
// [R12] Requests wait while converter busy, then run when free.
// [R13] Low byte controls pair 2 with same fields.
// [R14] Five-bit trigger select picks input; pair controls reset to zero.
module aptc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] trig_in,
  input wire logic conv_done,
  output logic conv_clk,
  output logic [1:0] sample_en,
  output logic [1:0] conv_start,
  output logic [1:0] irq_req
);
  import aptc_pkg::*;
  aptc_pair_if p3 ();
  aptc_pair_if p2 ();

  logic [15:0] main_ctrl;
  logic [15:0] next_main_ctrl;
  logic [15:0] pair_ctrl;
  logic [15:0] next_pair_ctrl;
  logic [31:0] trig_m;
  logic [31:0] trig_s;
  logic [31:0] trig_d;
  logic [2:0] div_cnt;
  logic [2:0] next_div_cnt;
  logic tick;
  logic next_tick;
  logic cclk;
  logic next_cclk;
  logic busy3;
  logic busy2;
  logic next_busy3;
  logic next_busy2;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [1:0] next_sample_en;
  logic [1:0] next_conv_start;
  logic [1:0] next_irq;
  logic [31:0] trig_rise;
  logic hit3;
  logic hit2;
  logic wr;
  logic rd;
  logic mapped;
  logic grant3;
  logic grant2;
  logic on;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trig_m <= 32'h0;
      trig_s <= 32'h0;
      trig_d <= 32'h0;
    end else begin
      trig_m <= trig_in;
      trig_s <= trig_m;
      trig_d <= trig_s;
    end
  end

  assign trig_rise = trig_s & ~trig_d;
  assign on = main_ctrl[`APTC_MAIN_ON_BIT];
  // Soft trigger counts only while the pair selects the software source
  assign hit3 = on && (pair_ctrl[`APTC_P3_SEL_LSB +: `APTC_SEL_W] ==
    `APTC_SEL_SOFT ? pair_ctrl[`APTC_P3_SWT_BIT] :
    trig_rise[pair_ctrl[`APTC_P3_SEL_LSB +: `APTC_SEL_W]]); // see [R9] [R14]
  assign hit2 = on && (pair_ctrl[`APTC_P2_SEL_LSB +: `APTC_SEL_W] ==
    `APTC_SEL_SOFT ? pair_ctrl[`APTC_P2_SWT_BIT] :
    trig_rise[pair_ctrl[`APTC_P2_SEL_LSB +: `APTC_SEL_W]]); // see [R13]
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mapped = paddr == `APTC_OFF_MAIN_CTRL ||
    paddr == `APTC_OFF_PAIR_CTRL || paddr == `APTC_OFF_STATUS;
  // One shared converter; pair 3 wins a tie, the other waits
  assign grant3 = p3.want && !busy2 && !busy3; // see [R12]
  assign grant2 = p2.want && !busy3 && !busy2 && !grant3; // see [R12]

  assign p3.start = hit3 && !p3.pending; // see [R1]
  assign p2.start = hit2 && !p2.pending; // see [R1]
  assign p3.async_mode = main_ctrl[`APTC_MAIN_ASYNC_BIT];
  assign p2.async_mode = main_ctrl[`APTC_MAIN_ASYNC_BIT];
  assign p3.adc_tick = tick;
  assign p2.adc_tick = tick;
  assign p3.grant = grant3;
  assign p2.grant = grant2;
  assign p3.conv_done = conv_done && busy3;
  assign p2.conv_done = conv_done && busy2;

  aptc_pair_seq u_pair3 (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pif(p3)
  );

  aptc_pair_seq u_pair2 (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pif(p2)
  );

  always_comb begin
    next_div_cnt = div_cnt;
    next_tick = 1'b0;
    next_cclk = cclk;
    if (!on) begin
      next_div_cnt = 3'h0;
      next_cclk = 1'b0;
    end else if (div_cnt ==
        main_ctrl[`APTC_MAIN_DIV_LSB +: `APTC_MAIN_DIV_W]) begin
      next_div_cnt = 3'h0; // see [R4]
      next_tick = 1'b1;
      next_cclk = 1'b1;
    end else begin
      next_div_cnt = div_cnt + 3'h1;
      next_cclk = 1'b0;
    end
  end

  always_comb begin
    next_main_ctrl = main_ctrl;
    next_pair_ctrl = pair_ctrl;
    if (wr && paddr == `APTC_OFF_MAIN_CTRL) begin
      if (on) begin
        // Mode and divider frozen while running to avoid a glitched clock
        next_main_ctrl[`APTC_MAIN_ON_BIT] = pwdata[`APTC_MAIN_ON_BIT]; // see [R5]
      end else begin
        next_main_ctrl = pwdata[15:0] & `APTC_MAIN_WMASK; // see [R5] [R6]
      end
    end
    if (wr && paddr == `APTC_OFF_PAIR_CTRL) begin
      next_pair_ctrl = pwdata[15:0];
    end
    // Pending is owned by the sequencers; shown here for readback
    // Start counts too, so pending shows at the edge that clears soft bit
    next_pair_ctrl[`APTC_P3_PEND_BIT] = p3.pending || p3.start; // see [R10]
    next_pair_ctrl[`APTC_P2_PEND_BIT] = p2.pending || p2.start; // see [R10]
    if (p3.start) begin
      next_pair_ctrl[`APTC_P3_SWT_BIT] = 1'b0; // see [R10]
    end
    if (p2.start) begin
      next_pair_ctrl[`APTC_P2_SWT_BIT] = 1'b0; // see [R10]
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    next_pready = psel && !pready;
    next_pslverr = psel && !pready && !mapped;
    if (psel && !pready) begin
      case (paddr)
        `APTC_OFF_MAIN_CTRL: next_prdata = {16'h0, main_ctrl}; // see [R6]
        `APTC_OFF_PAIR_CTRL: next_prdata = {16'h0, pair_ctrl};
        `APTC_OFF_STATUS: next_prdata = {28'h0, busy3, busy2,
          p3.pending, p2.pending};
        default: next_prdata = 32'h0;
      endcase
    end
    next_busy3 = (busy3 && !conv_done) || grant3;
    next_busy2 = (busy2 && !conv_done) || grant2;
    next_sample_en = {p3.sampling, p2.sampling};
    next_conv_start = {grant3, grant2};
    next_irq = {p3.irq_event && pair_ctrl[`APTC_P3_IRQ_BIT],
      p2.irq_event && pair_ctrl[`APTC_P2_IRQ_BIT]}; // see [R7] [R13]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      main_ctrl <= {13'h0, `APTC_MAIN_DIV_RESET};
      pair_ctrl <= 16'h0; // see [R14]
      div_cnt <= 3'h0;
      tick <= 1'b0;
      cclk <= 1'b0;
      busy3 <= 1'b0;
      busy2 <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sample_en <= 2'h0;
      conv_start <= 2'h0;
      irq_req <= 2'h0;
      conv_clk <= 1'b0;
    end else begin
      main_ctrl <= next_main_ctrl;
      pair_ctrl <= next_pair_ctrl;
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      cclk <= next_cclk;
      busy3 <= next_busy3;
      busy2 <= next_busy2;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      sample_en <= next_sample_en;
      conv_start <= next_conv_start;
      irq_req <= next_irq;
      conv_clk <= cclk;
    end
  end
endmodule : aptc_top
